// ==== core/ubr_pkg.sv ====
package ubr_pkg;

    // ------------------------------------------------------------
    // Field widths and limits
    // ------------------------------------------------------------
    localparam int PRS_W = 4;
    localparam int DIV_W = 7;
    localparam logic [3:0] PRS_MAX = 4'hb;
    localparam logic [6:0] DIV_MIN = 7'h03;
    localparam logic [6:0] DIV_RESET = 7'h7f;
    localparam int TIMER_W = 20;
    localparam logic [3:0] BITS_RESET = 4'h0;

    // ------------------------------------------------------------
    // Receive data length and parity modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UBR_LEN_7 = 2'h0,
        UBR_LEN_8 = 2'h1,
        UBR_LEN_9 = 2'h2,
        UBR_LEN_16 = 2'h3
    } ubr_len_t;

    typedef enum logic [1:0] {
        UBR_PAR_NONE = 2'h0,
        UBR_PAR_ZERO = 2'h1,
        UBR_PAR_EVEN = 2'h2,
        UBR_PAR_ODD = 2'h3
    } ubr_par_t;

    typedef struct packed {
        logic channel_clock_select_bit;
        logic [3:0] low_prescaler_field;
        logic [3:0] high_prescaler_field;
        logic [6:0] divider;
        ubr_len_t len;
        ubr_par_t par;
        logic lsb_first;
        logic invert;
    } ubr_cfg_t;

    typedef struct packed {
        logic buffer_full_flag;
        logic framing_error_flag;
        logic parity_error_flag;
        logic overrun_error_flag;
    } ubr_status_t;

    typedef enum logic [3:0] {
        UBR_IDLE = 4'b0001,
        UBR_START = 4'b0010,
        UBR_DATA = 4'b0100,
        UBR_STOP = 4'b1000
    } ubr_state_t;

endpackage

// ==== core/ubr_prescaler.sv ====
`timescale 1ns/100ps
module ubr_prescaler
    import ubr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic channel_clock_select_bit,
    input wire logic [3:0] low_prescaler_field,
    input wire logic [3:0] high_prescaler_field,
    output logic op_tick,
    output logic prohibited
);

    typedef struct packed {
        logic [10:0] count;
    } ubr_pre_st_t;

    ubr_pre_st_t st;
    ubr_pre_st_t next_st;
    logic [3:0] k;
    logic [10:0] mask;

    always_comb begin
        k = channel_clock_select_bit ? high_prescaler_field : low_prescaler_field;
        prohibited = k > PRS_MAX;
        mask = 11'h7ff >> (4'hb - (prohibited ? PRS_MAX : k));
        op_tick = run && !prohibited && ((st.count & mask) == 11'h000);
        next_st = st;
        if (!run) begin
            next_st.count = 11'h000;
        end else begin
            next_st.count = st.count + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ==== core/ubr_receiver.sv ====
`timescale 1ns/100ps
// Contract
// - Clock select bit 0 picks low prescaler field, 1 picks high field.
// - Prescaler value k 0..11 divides system clock by 2^k; others prohibited.
// - Bit rate is operation clock over divider plus one, over two.
// - After start bit, latch points are timed from the divider field.
// - Frame length is start plus data plus parity (absent when parity is none) plus stop bit.
// - Reading receive data clears buffer-full; reception never waits for the read.
// - Writing 1 to a flag-clear trigger bit clears that error flag.
// - Stop trigger clears channel enable status and halts the channel.
// - Software resynchronises, then restarts from a fresh start bit.
// - Start trigger sets channel enable status and resumes reception; a stop trigger in the same cycle wins and leaves it clear.
module ubr_receiver
    import ubr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rxd,
    input wire ubr_cfg_t cfg,
    input wire logic channel_start_trigger,
    input wire logic channel_stop_trigger,
    input wire logic data_read,
    input wire logic status_clear_valid,
    input wire ubr_status_t flag_clear_trigger_register,
    output logic channel_enable_status,
    output ubr_status_t channel_status_register,
    output logic [15:0] rx_data,
    output logic frame_done,
    output logic setting_prohibited
);

    typedef struct packed {
        logic rx_meta;
        logic rx_sync;
        ubr_state_t state;
        logic [6:0] tick_cnt;
        logic half;
        logic [4:0] bit_cnt;
        logic [15:0] shreg;
        logic par_acc;
        logic par_bit;
        logic enable;
        ubr_status_t flags;
        logic [15:0] data;
        logic done;
    } ubr_rx_st_t;

    ubr_rx_st_t st;
    ubr_rx_st_t next_st;
    logic op_tick;
    logic pre_bad;
    logic rx_level;
    logic latch;
    logic [4:0] data_bits;
    logic par_en;
    logic par_exp;

    // ------------------------------------------------------------
    // Operation clock
    // ------------------------------------------------------------
    ubr_prescaler u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .run(st.enable),
        .channel_clock_select_bit(cfg.channel_clock_select_bit),
        .low_prescaler_field(cfg.low_prescaler_field),
        .high_prescaler_field(cfg.high_prescaler_field),
        .op_tick(op_tick),
        .prohibited(pre_bad)
    );

    function automatic logic [4:0] len_bits(input ubr_len_t l);
        unique case (l)
            UBR_LEN_7: len_bits = 5'd7;
            UBR_LEN_8: len_bits = 5'd8;
            UBR_LEN_9: len_bits = 5'd9;
            UBR_LEN_16: len_bits = 5'd16;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Receive sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        rx_level = st.rx_sync ^ cfg.invert;
        data_bits = len_bits(cfg.len);
        par_en = cfg.par != UBR_PAR_NONE;
        par_exp = (cfg.par == UBR_PAR_ODD) ? ~st.par_acc : st.par_acc;
        // One bit is two halves of (divider+1) operation clocks
        latch = op_tick && (st.tick_cnt == cfg.divider) && st.half;
        next_st.rx_meta = rxd;
        next_st.rx_sync = st.rx_meta;
        next_st.done = 1'b0;
        if (op_tick && st.state != UBR_IDLE) begin
            if (st.tick_cnt == cfg.divider) begin
                next_st.tick_cnt = 7'h00;
                next_st.half = ~st.half;
            end else begin
                next_st.tick_cnt = st.tick_cnt + 7'h01;
            end
        end
        unique case (st.state)
            UBR_IDLE: begin
                if (st.enable && !rx_level) begin
                    next_st.state = UBR_START;
                    next_st.tick_cnt = 7'h00;
                    next_st.half = 1'b0;
                end
            end
            UBR_START: begin
                // Mid start bit check rejects glitches
                if (op_tick && st.tick_cnt == cfg.divider && !st.half) begin
                    if (rx_level) begin
                        next_st.state = UBR_IDLE;
                    end else begin
                        next_st.state = UBR_DATA;
                        next_st.half = 1'b0;
                        next_st.tick_cnt = 7'h00;
                        next_st.bit_cnt = 5'h00;
                        next_st.par_acc = 1'b0;
                    end
                end
            end
            UBR_DATA: begin
                if (latch) begin
                    if (st.bit_cnt < data_bits) begin
                        next_st.par_acc = st.par_acc ^ rx_level;
                        if (cfg.lsb_first) begin
                            next_st.shreg = {rx_level, st.shreg[15:1]};
                        end else begin
                            next_st.shreg = {st.shreg[14:0], rx_level};
                        end
                    end else begin
                        next_st.par_bit = rx_level;
                    end
                    next_st.bit_cnt = st.bit_cnt + 5'h01;
                    if (st.bit_cnt + 5'h01 == data_bits + {4'h0, par_en}) begin
                        next_st.state = UBR_STOP;
                    end
                end
            end
            UBR_STOP: begin
                if (latch) begin
                    next_st.state = UBR_IDLE;
                    next_st.done = 1'b1;
                    // MSB-first leaves stale upper bits in the shifter, so mask them
                    next_st.data = cfg.lsb_first ?
                        (st.shreg >> (5'd16 - data_bits)) :
                        (st.shreg & ~(16'hffff << data_bits));
                    next_st.flags.buffer_full_flag = 1'b1;
                    if (st.flags.buffer_full_flag) begin
                        next_st.flags.overrun_error_flag = 1'b1;
                    end
                    if (!rx_level) begin
                        next_st.flags.framing_error_flag = 1'b1;
                    end
                    if ((cfg.par == UBR_PAR_EVEN || cfg.par == UBR_PAR_ODD)
                        && st.par_bit != par_exp) begin
                        next_st.flags.parity_error_flag = 1'b1;
                    end
                end
            end
            default: next_st.state = UBR_IDLE;
        endcase
        // Flag clears lose to a same-cycle frame completion
        if (data_read && !next_st.done) begin
            next_st.flags.buffer_full_flag = 1'b0;
        end
        if (status_clear_valid && !next_st.done) begin
            if (flag_clear_trigger_register.framing_error_flag) begin
                next_st.flags.framing_error_flag = 1'b0;
            end
            if (flag_clear_trigger_register.parity_error_flag) begin
                next_st.flags.parity_error_flag = 1'b0;
            end
            if (flag_clear_trigger_register.overrun_error_flag) begin
                next_st.flags.overrun_error_flag = 1'b0;
            end
        end
        if (channel_stop_trigger) begin
            next_st.enable = 1'b0;
            next_st.state = UBR_IDLE;
        end else if (channel_start_trigger) begin
            next_st.enable = 1'b1;
            next_st.state = UBR_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '{rx_meta: 1'b1, rx_sync: 1'b1, state: UBR_IDLE,
                    shreg: 16'h0000, data: 16'h0000, flags: '0, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign channel_enable_status = st.enable;
    assign channel_status_register = st.flags;
    assign rx_data = st.data;
    assign frame_done = st.done;
    assign setting_prohibited = pre_bad || (cfg.divider < DIV_MIN);

endmodule

// ==== verification/ubr_receiver_assertions.sv ====
`timescale 1ns/100ps
module ubr_receiver_assertions
    import ubr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ubr_cfg_t cfg,
    input wire logic channel_start_trigger,
    input wire logic channel_stop_trigger,
    input wire logic data_read,
    input wire logic status_clear_valid,
    input wire ubr_status_t flag_clear_trigger_register,
    input wire logic channel_enable_status,
    input wire ubr_status_t channel_status_register,
    input wire logic frame_done,
    input wire logic setting_prohibited
);
    // Short aliases keep the properties readable
    wire logic buf_full = channel_status_register.buffer_full_flag;
    wire logic frame_err = channel_status_register.framing_error_flag;
    wire logic overrun = channel_status_register.overrun_error_flag;
    wire logic [3:0] k = cfg.channel_clock_select_bit ?
        cfg.high_prescaler_field : cfg.low_prescaler_field;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_start;
        channel_start_trigger && !channel_stop_trigger |=> channel_enable_status;
    endproperty
    a_start: assert property (p_start) else $error("start did not enable");
    property p_stop; channel_stop_trigger |=> !channel_enable_status; endproperty
    a_stop: assert property (p_stop) else $error("stop did not halt");
    property p_read; data_read |=> !buf_full || frame_done; endproperty
    a_read: assert property (p_read) else $error("read left buffer full");
    property p_clear;
        status_clear_valid && flag_clear_trigger_register.framing_error_flag
            |=> !frame_err || frame_done;
    endproperty
    a_clear: assert property (p_clear) else $error("flag clear ignored");
    property p_overrun; $rose(frame_done) && $past(buf_full) |-> overrun; endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_done; frame_done |-> buf_full ##1 !frame_done; endproperty
    a_done: assert property (p_done) else $error("frame end malformed");
    property p_halt; !channel_enable_status |=> !frame_done; endproperty
    a_halt: assert property (p_halt) else $error("frame while halted");
    property p_prohib;
        setting_prohibited == (k > PRS_MAX || cfg.divider < DIV_MIN);
    endproperty
    a_prohib: assert property (p_prohib) else $error("prohibited flag wrong");
    c_overrun: cover property (frame_done && overrun);
    c_frame_err: cover property (frame_done && frame_err);
    c_parity_err: cover property (frame_done && channel_status_register.parity_error_flag);
endmodule

bind ubr_receiver ubr_receiver_assertions u_chk (
    .clk(clk),
    .rst_n(rst_n),
    .cfg(cfg),
    .channel_start_trigger(channel_start_trigger),
    .channel_stop_trigger(channel_stop_trigger),
    .data_read(data_read),
    .status_clear_valid(status_clear_valid),
    .flag_clear_trigger_register(flag_clear_trigger_register),
    .channel_enable_status(channel_enable_status),
    .channel_status_register(channel_status_register),
    .frame_done(frame_done),
    .setting_prohibited(setting_prohibited)
);

// ==== verification/ubr_receiver_bench.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ubr_receiver_bench
    import ubr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0, stop = 1'b0, rd = 1'b0, clr_v = 1'b0;
    logic rxd, en, done, prohib;
    logic [15:0] data;
    ubr_status_t clr = '0;
    ubr_status_t sts;
    ubr_cfg_t cfg = '{1'b0, 4'h0, 4'h1, 7'h03, UBR_LEN_8, UBR_PAR_EVEN, 1'b1, 1'b0};
    int err_total = 0, n_compared = 0;
    ubr_receiver uut (.clk(clk), .rst_n(rst_n), .rxd(rxd), .cfg(cfg),
        .channel_start_trigger(start), .channel_stop_trigger(stop), .data_read(rd),
        .status_clear_valid(clr_v), .flag_clear_trigger_register(clr),
        .channel_enable_status(en), .channel_status_register(sts), .rx_data(data),
        .frame_done(done), .setting_prohibited(prohib));
    ubr_remote_tx tx (.clk(clk), .rxd(rxd));
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Frame timing is judged from the start edge to the completion pulse
    task automatic frame(input int per, input logic [7:0] d, input logic par, input logic stp,
            input logic [3:0] exp_sts);
        int n;
        n = 0;
        fork
            tx.send(per, d, par, stp);
            while (done !== 1'b1 && n < 400) begin
                @(negedge clk);
                n++;
            end
        join
        if (n >= 400) begin
            err_total++;
            complete_run();
        end
        `CHK("latency", 1'b1, n >= 10 * per && n <= 11 * per + 4)
        `CHK("data", {8'h00, d}, data)
        `CHK("status", exp_sts, sts)
    endtask
    task automatic recover();
        pulse(rd);
        `CHK("buffer", 1'b0, sts.buffer_full_flag)
        clr = sts;
        pulse(clr_v);
        `CHK("flags", 4'h0, sts)
    endtask
    task automatic s_select();
        frame(8, 8'ha5, 1'b0, 1'b1, 4'h8);
        recover();
        pulse(stop);
        cfg.channel_clock_select_bit = 1'b1;
        pulse(start);
        frame(16, 8'h3c, 1'b0, 1'b1, 4'h8);
        recover();
        pulse(stop);
        cfg.channel_clock_select_bit = 1'b0;
        pulse(start);
    endtask
    task automatic s_errors();
        frame(8, 8'h5a, 1'b0, 1'b1, 4'h8);
        frame(8, 8'h01, 1'b1, 1'b1, 4'h9);
        recover();
        frame(8, 8'h07, 1'b0, 1'b1, 4'ha);
        recover();
        frame(8, 8'h81, 1'b0, 1'b0, 4'hc);
        recover();
        pulse(stop);
        `CHK("halted", 1'b0, en)
        pulse(start);
        `CHK("running", 1'b1, en)
        frame(8, 8'hc3, 1'b0, 1'b1, 4'h8);
        recover();
    endtask
    // Symmetric byte, so MSB-first data equals the sent value
    task automatic s_modes();
        pulse(stop);
        cfg.par = UBR_PAR_ODD;
        cfg.lsb_first = 1'b0;
        pulse(start);
        frame(8, 8'h81, 1'b1, 1'b1, 4'h8);
        recover();
        frame(8, 8'h81, 1'b0, 1'b1, 4'ha);
        recover();
    endtask
    task automatic s_prohibited();
        pulse(stop);
        for (int k = 0; k < 16; k++) begin
            cfg.low_prescaler_field = 4'(k);
            @(negedge clk);
            `CHK("prescaler", k > 11, prohib)
        end
        cfg.low_prescaler_field = 4'h0;
        for (int v = 0; v < 4; v++) begin
            cfg.divider = 7'(v);
            @(negedge clk);
            `CHK("divider", v < 3, prohib)
        end
        cfg.divider = 7'h03;
        pulse(start);
    endtask
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        pulse(start);
        `CHK("enable", 1'b1, en)
        s_select();
        s_errors();
        s_modes();
        s_prohibited();
        complete_run();
    end
endmodule

// ==== verification/ubr_remote_tx.sv ====
`timescale 1ns/100ps
module ubr_remote_tx (
    input wire logic clk,
    output logic rxd
);
    initial rxd = 1'b1;
    // Start, eight data bits LSB first, parity, stop; one idle cycle after
    task automatic send(input int per, input logic [7:0] d, input logic par, input logic stp);
        logic [10:0] f;
        f = {stp, par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd = f[i];
            repeat (per) @(negedge clk);
        end
        rxd = 1'b1;
        @(negedge clk);
    endtask
endmodule
